//--- common/mdio_regs.vh
`ifndef MDIO_REGS_VH
`define MDIO_REGS_VH

// register indices on the plain register port (word addressed)
`define MDIO_ADDR_W          4
`define MDIO_REG_CTRL        4'h0
`define MDIO_REG_STOPACT     4'h1
`define MDIO_REG_OUTSEL      4'h2
`define MDIO_REG_CMPRANGE    4'h3
`define MDIO_REG_SPEED0      4'h4
`define MDIO_REG_STATUS      4'h5
`define MDIO_REG_ALMCODE     4'h6
`define MDIO_REG_SPEEDOUT    4'h7
`define MDIO_REG_POSERR      4'h8

// ctrl register fields
`define MDIO_CTRL_POSMODE    0
`define MDIO_CTRL_BRAKEMOTOR 1

// reset values, completion range limits and the immediate-off stop action code
`define MDIO_STOPACT_RST     2'h0
`define MDIO_OUTSEL_RST      1'h0
`define MDIO_CMPRANGE_RST    7'h01
`define MDIO_CMPRANGE_MIN    7'h01
`define MDIO_CMPRANGE_MAX    7'h64
`define MDIO_STOPACT_IMMOFF  2'h2

// operation data numbers with a special meaning in position control
`define MDIO_OP_ELEC_HOME    3'h6
`define MDIO_OP_MECH_HOME    3'h7

// speed ramp direction codes
`define MDIO_DIR_STOP        2'h0
`define MDIO_DIR_CW          2'h1
`define MDIO_DIR_CCW         2'h2

// timing, in milliseconds, at 10 MHz (10000 cycles per ms)
`define MDIO_CLK_KHZ         10000
`define MDIO_CLEAR_HOLD_MS   500
`define MDIO_READOUT_HOLD_MS 100
`define MDIO_PULSE_MS        10
`define MDIO_GAP_MS          10
`define MDIO_DEBOUNCE_MS     1

`endif

//--- hdl/mdio_ctrl.v
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "mdio_regs.vh"

// Notes on behaviour
// - speed mode runs at selected entry speed
// - dropping direction input ramps speed down
// - clockwise or counterclockwise per run input
// - both run inputs on means ramp stop
// - select first, start edge begins operation
// - origin sensor normally closed, mech home
// - select bits form number 0 to 7
// - release input cuts current, frees brake
// - shared input: stop permit or alarm clear
// - permit off in motion stops instantly
// - stop action setting, default 0, 2 immediate
// - alarm stops motor, alarm output drops
// - clear held 0.5 s resets alarm
// - some alarms need power cycle
// - shared output: busy or torque, else pulses
// - busy while operating, off when complete
// - completion within 1 to 100 steps
// - clockwise run or start held 0.1 s reads code
// - overvoltage alarm gives three pulses
// - torque flag when limit reached
// - fixed inputs 0-8, outputs 0-1, spares assignable; here spare inputs only read in status, spare output held low
module mdio_ctrl #(
	parameter integer CLEAR_HOLD_CYC   = `MDIO_CLEAR_HOLD_MS * `MDIO_CLK_KHZ,
	parameter integer READOUT_HOLD_CYC = `MDIO_READOUT_HOLD_MS * `MDIO_CLK_KHZ,
	parameter integer PULSE_CYC        = `MDIO_PULSE_MS * `MDIO_CLK_KHZ,
	parameter integer GAP_CYC          = `MDIO_GAP_MS * `MDIO_CLK_KHZ,
	parameter integer DEBOUNCE_CYC     = `MDIO_DEBOUNCE_MS * `MDIO_CLK_KHZ,
	parameter integer SPEED_W          = 12,
	parameter integer POS_W            = 16,
	parameter integer ALMCODE_W        = 4
) (
	input  wire                     clk,
	input  wire                     rst_b,
	input  wire                     clockwise_run,
	input  wire                     counterclockwise_run,
	input  wire                     start_in,
	input  wire                     mech_origin_sensor,
	input  wire                     select_bit0,
	input  wire                     select_bit1,
	input  wire                     select_bit2,
	input  wire                     free_in,
	input  wire                     stop_clear_in,
	input  wire                     spare_input_a,
	input  wire                     spare_input_b,
	input  wire                     alarm_event,
	input  wire [ALMCODE_W-1:0]     alarm_event_code,
	input  wire                     alarm_event_latching,
	input  wire                     torque_limit_reached,
	input  wire signed [POS_W-1:0]  position_error,
	input  wire                     op_done,
	input  wire [`MDIO_ADDR_W-1:0]  reg_addr,
	input  wire [15:0]              reg_wdata,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	output reg  [15:0]              reg_rdata,
	output wire                     alarm_out,
	output wire                     status_output_b,
	output wire                     spare_output,
	output reg  [SPEED_W-1:0]       speed_cmd,
	output reg  [1:0]               dir_cmd,
	output reg                      current_on,
	output reg                      brake_hold,
	output reg                      op_start,
	output reg  [2:0]               op_number,
	output reg                      op_active,
	output reg                      home_sensor_hit
);
	localparam integer NIN = 11;
	localparam [1:0] PS_IDLE = 2'h0;
	localparam [1:0] PS_HIGH = 2'h1;
	localparam [1:0] PS_GAP  = 2'h2;
	localparam [1:0] PS_END  = 2'h3;

	// synchroniser and debounce per input
	wire [NIN-1:0] raw_in = {spare_input_b, spare_input_a, stop_clear_in, free_in,
		select_bit2, select_bit1, select_bit0, mech_origin_sensor, start_in,
		counterclockwise_run, clockwise_run};
	reg  [NIN-1:0] s1_q;
	reg  [NIN-1:0] s2_q;
	reg  [NIN-1:0] db_q;
	reg  [31:0]    db_cnt_q [0:NIN-1];
	integer i;
	integer j;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= {NIN{1'b0}};
			s2_q <= {NIN{1'b0}};
			db_q <= {NIN{1'b0}};
			for (i = 0; i < NIN; i = i + 1) begin
				db_cnt_q[i] <= 32'h0;
			end
		end else begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			for (i = 0; i < NIN; i = i + 1) begin
				// a level must stay steady this long before it is accepted
				if (s2_q[i] == db_q[i]) begin
					db_cnt_q[i] <= 32'h0;
				end else if (db_cnt_q[i] >= DEBOUNCE_CYC - 1) begin
					db_q[i]     <= s2_q[i];
					db_cnt_q[i] <= 32'h0;
				end else begin
					db_cnt_q[i] <= db_cnt_q[i] + 32'h1;
				end
			end
		end
	end

	wire cw_on    = db_q[0];
	wire ccw_on   = db_q[1];
	wire start_on = db_q[2];
	// normally closed: open contact (low) means the sensor has tripped
	wire origin_hit  = ~db_q[3];
	wire [2:0] sel_num = {db_q[6], db_q[5], db_q[4]};
	wire free_on  = db_q[7];
	// normally closed shared input: high level means permit / clear ON
	wire sc_on    = db_q[8];
	// spare inputs carry no function here; they only show in status

	// registers
	reg                   posmode_q;
	reg                   brakemotor_q;
	reg  [1:0]            stopact_q;
	reg                   outsel_q;
	reg  [6:0]            cmprange_q;
	reg  [SPEED_W-1:0]    speed_tab_q [0:7];
	reg                   alarm_q;
	reg                   alarm_latch_q;
	reg  [ALMCODE_W-1:0]  alarm_code_q;
	reg  [31:0]           clr_cnt_q;
	reg  [31:0]           ro_cnt_q;
	reg                   ro_done_q;
	reg  [1:0]            ps_q;
	reg  [31:0]           ps_cnt_q;
	reg  [ALMCODE_W-1:0]  ps_left_q;
	reg                   alp_q;
	reg                   start_prev_q;

	wire ro_req   = cw_on | start_on;
	wire clr_ok   = alarm_q & ~alarm_latch_q;
	wire [POS_W-1:0] abs_err = position_error[POS_W-1] ? -position_error : position_error;
	wire settled  = abs_err <= {{(POS_W-7){1'b0}}, cmprange_q};
	wire permit   = sc_on & ~alarm_q;

	// register write port
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			posmode_q    <= 1'b0;
			brakemotor_q <= 1'b0;
			stopact_q    <= `MDIO_STOPACT_RST;
			outsel_q     <= `MDIO_OUTSEL_RST;
			cmprange_q   <= `MDIO_CMPRANGE_RST;
			for (j = 0; j < 8; j = j + 1) begin
				speed_tab_q[j] <= {SPEED_W{1'b0}};
			end
		end else if (reg_wr) begin
			if (reg_addr == `MDIO_REG_CTRL) begin
				posmode_q    <= reg_wdata[`MDIO_CTRL_POSMODE];
				brakemotor_q <= reg_wdata[`MDIO_CTRL_BRAKEMOTOR];
			end
			if (reg_addr == `MDIO_REG_STOPACT) begin
				stopact_q <= reg_wdata[1:0];
			end
			if (reg_addr == `MDIO_REG_OUTSEL) begin
				outsel_q <= reg_wdata[0];
			end
			// out-of-range completion values are clamped
			if (reg_addr == `MDIO_REG_CMPRANGE) begin
				if (reg_wdata[6:0] < `MDIO_CMPRANGE_MIN || reg_wdata[15:7] != 9'h0) begin
					cmprange_q <= (reg_wdata[15:7] != 9'h0) ? `MDIO_CMPRANGE_MAX
						: `MDIO_CMPRANGE_MIN;
				end else if (reg_wdata[6:0] > `MDIO_CMPRANGE_MAX) begin
					cmprange_q <= `MDIO_CMPRANGE_MAX;
				end else begin
					cmprange_q <= reg_wdata[6:0];
				end
			end
			// speed table: entry index in write data top bits
			if (reg_addr == `MDIO_REG_SPEED0) begin
				speed_tab_q[reg_wdata[15:13]] <= reg_wdata[SPEED_W-1:0];
			end
		end
	end

	// register read port, data one cycle after the strobe
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0;
		end else if (reg_rd) begin
			case (reg_addr)
			`MDIO_REG_CTRL:     reg_rdata <= {14'h0, brakemotor_q, posmode_q};
			`MDIO_REG_STOPACT:  reg_rdata <= {14'h0, stopact_q};
			`MDIO_REG_OUTSEL:   reg_rdata <= {15'h0, outsel_q};
			`MDIO_REG_CMPRANGE: reg_rdata <= {9'h0, cmprange_q};
			`MDIO_REG_STATUS:   reg_rdata <= {4'h0, db_q, alarm_q};
			`MDIO_REG_ALMCODE:  reg_rdata <= {{(16-ALMCODE_W-1){1'b0}}, alarm_latch_q,
				alarm_code_q};
			`MDIO_REG_SPEEDOUT: reg_rdata <= {{(16-SPEED_W){1'b0}}, speed_cmd};
			`MDIO_REG_POSERR:   reg_rdata <= {{(16-POS_W){1'b0}}, abs_err};
			default:            reg_rdata <= 16'h0;
			endcase
		end
	end

	// alarm state and clear
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_q       <= 1'b0;
			alarm_latch_q <= 1'b0;
			alarm_code_q  <= {ALMCODE_W{1'b0}};
			clr_cnt_q     <= 32'h0;
		end else begin
			if (clr_ok && sc_on) begin
				clr_cnt_q <= (clr_cnt_q < CLEAR_HOLD_CYC) ? clr_cnt_q + 32'h1 : clr_cnt_q;
			end else begin
				clr_cnt_q <= 32'h0;
			end
			// a new alarm wins over a clear in the same cycle
			if (alarm_event && !alarm_q) begin
				alarm_q       <= 1'b1;
				alarm_code_q  <= alarm_event_code;
				alarm_latch_q <= alarm_event_latching;
			end else if (clr_ok && clr_cnt_q >= CLEAR_HOLD_CYC - 1 && !alarm_event) begin
				alarm_q   <= 1'b0;
				clr_cnt_q <= 32'h0;
			end
		end
	end

	// alarm code readout pulse train
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ro_cnt_q  <= 32'h0;
			ro_done_q <= 1'b0;
			ps_q      <= PS_IDLE;
			ps_cnt_q  <= 32'h0;
			ps_left_q <= {ALMCODE_W{1'b0}};
			alp_q     <= 1'b0;
		end else begin
			if (alarm_q && ro_req) begin
				ro_cnt_q <= (ro_cnt_q < READOUT_HOLD_CYC) ? ro_cnt_q + 32'h1 : ro_cnt_q;
			end else begin
				ro_cnt_q  <= 32'h0;
				ro_done_q <= 1'b0;
			end
			case (ps_q)
			PS_IDLE: begin
				alp_q <= 1'b0;
				// one train per hold; release and hold again for another
				if (alarm_q && ro_req && !ro_done_q
					&& ro_cnt_q >= READOUT_HOLD_CYC - 1) begin
					ro_done_q <= 1'b1;
					if (alarm_code_q != {ALMCODE_W{1'b0}}) begin
						ps_left_q <= alarm_code_q;
						ps_cnt_q  <= 32'h0;
						alp_q     <= 1'b1;
						ps_q      <= PS_HIGH;
					end
				end
			end
			PS_HIGH: begin
				if (ps_cnt_q >= PULSE_CYC - 1) begin
					alp_q     <= 1'b0;
					ps_cnt_q  <= 32'h0;
					ps_left_q <= ps_left_q - 1'b1;
					ps_q      <= (ps_left_q == 1) ? PS_END : PS_GAP;
				end else begin
					ps_cnt_q <= ps_cnt_q + 32'h1;
				end
			end
			PS_GAP: begin
				if (ps_cnt_q >= GAP_CYC - 1) begin
					alp_q    <= 1'b1;
					ps_cnt_q <= 32'h0;
					ps_q     <= PS_HIGH;
				end else begin
					ps_cnt_q <= ps_cnt_q + 32'h1;
				end
			end
			PS_END: begin
				alp_q <= 1'b0;
				ps_q  <= PS_IDLE;
			end
			default: begin
				alp_q <= 1'b0;
				ps_q  <= PS_IDLE;
			end
			endcase
			if (!alarm_q) begin
				ps_q  <= PS_IDLE;
				alp_q <= 1'b0;
			end
		end
	end

	// motion control
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			speed_cmd       <= {SPEED_W{1'b0}};
			dir_cmd         <= `MDIO_DIR_STOP;
			current_on      <= 1'b0;
			brake_hold      <= 1'b1;
			op_start        <= 1'b0;
			op_number       <= 3'h0;
			op_active       <= 1'b0;
			home_sensor_hit <= 1'b0;
			start_prev_q    <= 1'b0;
		end else begin
			op_start        <= 1'b0;
			start_prev_q    <= start_on;
			home_sensor_hit <= posmode_q & op_active & (op_number == `MDIO_OP_MECH_HOME)
				& origin_hit;
			if (alarm_q || !permit) begin
				// instant stop: no ramp, brake holds the load when brakemotor_q is set and release is off
				speed_cmd  <= {SPEED_W{1'b0}};
				op_active  <= 1'b0;
				brake_hold <= brakemotor_q & ~free_on;
				current_on <= ~alarm_q & ~free_on
					& (stopact_q != `MDIO_STOPACT_IMMOFF);
			end else if (free_on) begin
				current_on <= 1'b0;
				brake_hold <= 1'b0;
				speed_cmd  <= {SPEED_W{1'b0}};
				op_active  <= 1'b0;
			end else begin
				current_on <= 1'b1;
				brake_hold <= 1'b0;
				if (!posmode_q) begin
					if (cw_on ^ ccw_on) begin
						// a direction change first ramps down through zero
						if (dir_cmd != (cw_on ? `MDIO_DIR_CW : `MDIO_DIR_CCW)
							&& speed_cmd != {SPEED_W{1'b0}}) begin
							speed_cmd <= speed_cmd - 1'b1;
						end else begin
							dir_cmd <= cw_on ? `MDIO_DIR_CW : `MDIO_DIR_CCW;
							if (speed_cmd < speed_tab_q[sel_num]) begin
								speed_cmd <= speed_cmd + 1'b1;
							end else if (speed_cmd > speed_tab_q[sel_num]) begin
								speed_cmd <= speed_cmd - 1'b1;
							end
						end
						op_active <= 1'b1;
					end else begin
						// released, or both on: decelerate to stop
						if (speed_cmd != {SPEED_W{1'b0}}) begin
							speed_cmd <= speed_cmd - 1'b1;
						end else begin
							dir_cmd   <= `MDIO_DIR_STOP;
							op_active <= 1'b0;
						end
					end
				end else begin
					// select lines are sampled when start rises
					if (start_on && !start_prev_q && !op_active) begin
						op_number <= sel_num;
						op_start  <= 1'b1;
						op_active <= 1'b1;
					// done from the previous move may linger one cycle past start
					end else if (op_active && !op_start && op_done && settled) begin
						op_active <= 1'b0;
					end
				end
			end
		end
	end

	wire busy_ind  = op_active | op_start;
	wire func_out  = outsel_q ? torque_limit_reached : busy_ind;

	// normally closed: high while healthy
	assign alarm_out       = ~alarm_q;
	assign status_output_b = alarm_q ? alp_q : func_out;
	assign spare_output    = 1'b0;
endmodule

//--- test/mdio_ctrl_bench.sv
`define MDIO_CMP(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fail_count++; \
	$display("unexpected %s expected %h seen %h", nm, e, s); end end
module mdio_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct { string nm; logic [15:0] v; } mdio_note_t;
	reg clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	reg [9:0] line_req = 10'h080;
	reg ev = 1'b0, ev_latch = 1'b0, torque = 1'b0;
	reg [3:0] ev_code = 4'h0, reg_addr = 4'h0;
	reg [15:0] reg_wdata = 16'h0000;
	wire [9:0] line_q;
	wire [15:0] reg_rdata, pos_err;
	wire [11:0] speed_cmd;
	wire [2:0] op_number;
	wire [1:0] dir_cmd;
	wire op_done, origin, alarm_out, status_b, current_on, brake_hold, op_start, home_hit;
	integer fail_count = 0, num_checks = 0, seed = 32'hdb0410b8, i, n, pulses = 0;
	mdio_note_t notes[$];
	event look;
	mdio_host_model mdio_host_model_i (.clk(clk), .rst_b(rst_b), .line_req(line_req),
		.op_start(op_start), .op_number(op_number), .line_q(line_q), .op_done(op_done),
		.position_error(pos_err), .mech_origin_sensor(origin));
	mdio_ctrl #(.CLEAR_HOLD_CYC(20), .READOUT_HOLD_CYC(10), .PULSE_CYC(3), .GAP_CYC(3),
		.DEBOUNCE_CYC(2)) mdio_ctrl_i (.clk(clk), .rst_b(rst_b),
		.clockwise_run(line_q[0]), .counterclockwise_run(line_q[1]), .start_in(line_q[2]),
		.mech_origin_sensor(origin), .select_bit0(line_q[3]), .select_bit1(line_q[4]),
		.select_bit2(line_q[5]), .free_in(line_q[6]), .stop_clear_in(line_q[7]),
		.spare_input_a(line_q[8]), .spare_input_b(line_q[9]), .alarm_event(ev),
		.alarm_event_code(ev_code), .alarm_event_latching(ev_latch),
		.torque_limit_reached(torque), .position_error(pos_err), .op_done(op_done),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .alarm_out(alarm_out), .status_output_b(status_b),
		.spare_output(), .speed_cmd(speed_cmd), .dir_cmd(dir_cmd), .current_on(current_on),
		.brake_hold(brake_hold), .op_start(op_start), .op_number(op_number), .op_active(),
		.home_sensor_hit(home_hit));
	initial begin
		forever #50 clk = ~clk;
	end
	function automatic logic [15:0] obs(input string nm);
		case (nm)
			"alarm": obs = {15'h0, alarm_out};
			"status": obs = {15'h0, status_b};
			"current": obs = {15'h0, current_on};
			"brake": obs = {15'h0, brake_hold};
			"home": obs = {15'h0, home_hit};
			"dir": obs = {14'h0, dir_cmd};
			"moving": obs = {15'h0, |speed_cmd};
			"speed": obs = {4'h0, speed_cmd};
			default: obs = pulses[15:0];
		endcase
	endfunction
	task automatic take(input logic [15:0] seen);
		mdio_note_t t;
		if (notes.size() == 0) begin
			fail_count++;
			$display("unexpected result with nothing noted");
		end else begin
			t = notes.pop_front();
			`MDIO_CMP(t.nm, t.v, seen)
		end
	endtask
	// results are taken from pre-edge values, so design updates never race
	always @(posedge clk) begin
		rd_d <= reg_rd;
		if (rd_d) take(reg_rdata);
		if (op_start === 1'b1) take({13'h0, op_number});
	end
	always @(look) take(obs(notes[0].nm));
	task automatic tick(input integer k);
		repeat (k) @(posedge clk);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic expect_port(input string nm, input logic [15:0] v);
		notes.push_back('{nm, v});
		#1;
		-> look;
	endtask
	task automatic wr(input [3:0] a, input [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input [3:0] a, input [15:0] e, input string nm);
		notes.push_back('{nm, e});
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic lines(input [9:0] v, input integer k);
		@(posedge clk);
		line_req <= v;
		tick(k);
	endtask
	task automatic raise(input [3:0] code, input latch);
		@(posedge clk);
		ev <= 1'b1;
		ev_code <= code;
		ev_latch <= latch;
		@(posedge clk);
		ev <= 1'b0;
		tick(3);
	endtask
	task automatic readout(input integer b, input integer k);
		integer prev;
		prev = 0;
		pulses = 0;
		@(posedge clk);
		line_req[b] <= 1'b1;
		repeat (80) begin
			@(posedge clk);
			#1;
			if (status_b === 1'b1 && prev == 0) pulses++;
			prev = (status_b === 1'b1);
		end
		@(posedge clk);
		line_req[b] <= 1'b0;
		expect_port("pulses", k[15:0]);
	endtask
	initial begin
		tick(3);
		rst_b <= 1'b1;
		rd(4'h1, 16'h0000, "stop_action");
		rd(4'h2, 16'h0000, "out_select");
		rd(4'h3, 16'h0001, "range");
		rd(4'hF, 16'h0000, "unmapped");
		wr(4'h3, 16'h0000);
		rd(4'h3, 16'h0001, "range_low");
		wr(4'h3, 16'h00C8);
		rd(4'h3, 16'h0064, "range_high");
		wr(4'h1, 16'h0002);
		rd(4'h1, 16'h0002, "stop_action_set");
		$display("test registers done");
		n = 8 + ($random(seed) & 32'h3F);
		wr(4'h4, {3'h3, 1'b0, n[11:0]});
		wr(4'h0, 16'h0002);
		lines(10'h099, 100);
		rd(4'h7, n[15:0], "speed_cw");
		expect_port("dir", 16'h0001);
		lines(10'h09B, 8);
		expect_port("moving", 16'h0001);
		tick(100);
		rd(4'h7, 16'h0000, "speed_both");
		lines(10'h09A, 100);
		expect_port("dir", 16'h0002);
		lines(10'h098, 8);
		expect_port("moving", 16'h0001);
		tick(100);
		rd(4'h7, 16'h0000, "speed_off");
		$display("test speed done");
		lines(10'h099, 100);
		lines(10'h019, 10);
		expect_port("speed", 16'h0000);
		expect_port("current", 16'h0000);
		expect_port("brake", 16'h0001);
		lines(10'h099, 100);
		lines(10'h0D9, 10);
		expect_port("current", 16'h0000);
		expect_port("brake", 16'h0000);
		lines(10'h080, 100);
		$display("test stop and release done");
		wr(4'h0, 16'h0003);
		for (i = 0; i < 8; i++) begin
			lines({2'($random(seed)), 2'b10, i[2:0], 3'h0}, 2);
			@(posedge clk);
			line_req[2] <= 1'b1;
			notes.push_back('{"op_number", {13'h0, i[2:0]}});
			n = 0;
			while (op_start !== 1'b1) begin
				@(posedge clk);
				#1;
				n++;
				if (n > 60) begin
					fail_count++;
					$display("unexpected wait for op_start ran out");
					summarize;
				end
			end
			tick(3);
			expect_port("status", 16'h0001);
			tick(14);
			if (i == 7) expect_port("home", 16'h0001);
			tick(30);
			expect_port("status", 16'h0000);
			@(posedge clk);
			line_req[2] <= 1'b0;
		end
		$display("test position done");
		wr(4'h2, 16'h0001);
		@(posedge clk);
		torque <= 1'b1;
		tick(6);
		expect_port("status", 16'h0001);
		@(posedge clk);
		torque <= 1'b0;
		tick(6);
		expect_port("status", 16'h0000);
		$display("test torque done");
		wr(4'h0, 16'h0002);
		lines(10'h000, 8);
		raise(4'h3, 1'b0);
		expect_port("alarm", 16'h0000);
		readout(0, 3);
		lines(10'h080, 10);
		lines(10'h000, 8);
		expect_port("alarm", 16'h0000);
		lines(10'h080, 35);
		expect_port("alarm", 16'h0001);
		lines(10'h000, 8);
		raise(4'h5, 1'b1);
		readout(2, 5);
		lines(10'h080, 40);
		expect_port("alarm", 16'h0000);
		@(posedge clk);
		rst_b <= 1'b0;
		tick(3);
		rst_b <= 1'b1;
		tick(2);
		expect_port("alarm", 16'h0001);
		rd(4'h1, 16'h0000, "stop_action_again");
		$display("test alarm done");
		summarize;
	end
endmodule

//--- test/mdio_ctrl_monitor.sv
module mdio_ctrl_monitor #(
	parameter integer CLEAR_HOLD_CYC = 20,
	parameter integer SPEED_W        = 12
) (
	input wire               clk,
	input wire               rst_b,
	input wire               clockwise_run,
	input wire               counterclockwise_run,
	input wire               free_in,
	input wire               stop_clear_in,
	input wire               alarm_event,
	input wire               alarm_out,
	input wire               status_output_b,
	input wire               spare_output,
	input wire [SPEED_W-1:0] speed_cmd,
	input wire               current_on,
	input wire               op_active
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking mon_cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// raw count is never below the debounced count the design uses
	reg [31:0] hold_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			hold_q <= 32'h0;
		else if (!stop_clear_in)
			hold_q <= 32'h0;
		else if (hold_q != 32'hFFFFFFFF)
			hold_q <= hold_q + 32'h1;
	end
	chk_spare_low: assert property (spare_output == 1'b0)
		else $error("spare output driven high");
	chk_free_cut: assert property (free_in [*8] |-> !current_on)
		else $error("current on while release held");
	chk_ramp_down: assert property
		((clockwise_run == counterclockwise_run) [*8]
		|-> speed_cmd <= $past(speed_cmd))
		else $error("speed rises without a single run input");
	chk_permit_stop: assert property
		((!stop_clear_in && alarm_out) [*8] |-> speed_cmd == 0)
		else $error("motor not stopped after permit drop");
	chk_alarm_raise: assert property (alarm_event && alarm_out |-> ##[1:3] !alarm_out)
		else $error("alarm output not dropped");
	chk_alarm_halt: assert property
		(!alarm_out && !$past(alarm_out) |-> speed_cmd <= $past(speed_cmd))
		else $error("speed rises during alarm");
	chk_alarm_idle: assert property
		(!alarm_out && !$past(alarm_out) |-> !op_active)
		else $error("operation still active during alarm");
	chk_clear_hold: assert property ($rose(alarm_out) |-> hold_q >= CLEAR_HOLD_CYC)
		else $error("alarm cleared by a short hold");
	chk_pulse_shape: assert property
		($rose(status_output_b) && !alarm_out
		|-> status_output_b [*3] ##1 !status_output_b [*3])
		else $error("alarm pulse width or gap wrong");
endmodule

bind mdio_ctrl mdio_ctrl_monitor #(.CLEAR_HOLD_CYC(CLEAR_HOLD_CYC), .SPEED_W(SPEED_W))
	mdio_ctrl_monitor_i (.clk(clk), .rst_b(rst_b), .clockwise_run(clockwise_run),
	.counterclockwise_run(counterclockwise_run), .free_in(free_in),
	.stop_clear_in(stop_clear_in), .alarm_event(alarm_event), .alarm_out(alarm_out),
	.status_output_b(status_output_b), .spare_output(spare_output),
	.speed_cmd(speed_cmd), .current_on(current_on), .op_active(op_active));

//--- test/mdio_host_model.sv
module mdio_host_model (
	input  wire        clk,
	input  wire        rst_b,
	input  wire [9:0]  line_req,
	input  wire        op_start,
	input  wire [2:0]  op_number,
	output reg  [9:0]  line_q = 10'h080,
	output reg         op_done = 1'b0,
	output reg  [15:0] position_error = 16'h0000,
	output reg         mech_origin_sensor = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [2:0] sel_age_q;
	reg [4:0] run_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_q <= 10'h080;
			sel_age_q <= 3'h0;
			run_q <= 5'h00;
			op_done <= 1'b0;
			position_error <= 16'h0000;
			mech_origin_sensor <= 1'b1;
		end else begin
			line_q[9:3] <= line_req[9:3];
			line_q[1:0] <= line_req[1:0];
			// start waits until the select lines have been steady
			sel_age_q <= (line_req[5:3] != line_q[5:3]) ? 3'h0 : sel_age_q + {2'h0, ~&sel_age_q};
			line_q[2] <= line_req[2] & (&sel_age_q);
			run_q <= op_start ? 5'h14 : run_q - {4'h0, |run_q};
			op_done <= !op_start && (op_done || run_q == 5'h01);
			// error shrinks to zero as the move lands
			position_error <= {11'h000, run_q};
			// normally closed sensor opens late in a mechanical home move
			mech_origin_sensor <= !(op_number == 3'h7 && run_q != 5'h00 && run_q < 5'h0B);
		end
	end
endmodule
